// ===== stp_map.vh
// Constants for the 16-bit standard timer: PWM, single pulse and capture modes
// What this block does
// - Swap low: period match clears counter; period value*256 or 65536; duty is A.
// - Duty at or above period gives a 100% duty output.
// - Swap high: A match clears counter; duty is period value*256 or 65536.
// - PWM generation keeps running while the output is forced inactive or active.
// - Clear-source select is ignored in PWM; only swap chooses the clear.
// - Single pulse: trigger input active edge sets counter enable automatically.
// - Single pulse: enable rising starts counter and drives pulse leading edge.
// - Single pulse: enable clear or A match ends pulse; width is A+2 clocks with a tick every clock.
// - Single pulse: comparator A match raises the timer interrupt request.
// - Single pulse: counter zeroed only on enable rise; period, clear, swap ignored.
// - Capture: counting starts when software raises the counter enable.
// - Capture: selected edge on either input copies counter to A, raises interrupt.
// - Capture: counter free-runs regardless of pins until enable falls.
// - Capture: period match zeroes counter, raises interrupt; zero period is full range.
// - Capture: edge field 11 disables capture while counter keeps running.
// - Capture: no output; initial level, invert, clear and swap bits ignored.
// - Edge field: 00 rising, 01 falling, 10 both, 11 disabled.
// - Enable rise zeroes counter; enable fall holds residual count.
// - PWM: initial-level bit picks active level, invert bit inverts output.
`ifndef STP_MAP_VH
`define STP_MAP_VH
`define STP_MODE_CMP     2'h0
`define STP_MODE_CAPTURE 2'h1
`define STP_MODE_PWM     2'h2
`define STP_MODE_TIMER   2'h3
`define STP_IO_INACTIVE  2'h0
`define STP_IO_ACTIVE    2'h1
`define STP_IO_PWM       2'h2
`define STP_IO_SINGLE    2'h3
`define STP_EDGE_RISE    2'h0
`define STP_EDGE_FALL    2'h1
`define STP_EDGE_BOTH    2'h2
`define STP_EDGE_OFF     2'h3
`define STP_CNT_RST      16'h0000
`define STP_PERIOD_LSB   8
`endif

// ===== stp_timer.v
// Standard timer core covering PWM, single pulse and capture input modes
`timescale 1ns/100ps
`include "stp_map.vh"

module stp_timer (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        tick_i,
  input  wire        mode_select_hi_i,
  input  wire        mode_select_lo_i,
  input  wire        output_function_hi_i,
  input  wire        output_function_lo_i,
  input  wire        initial_level_select_i,
  input  wire        output_invert_i,
  input  wire        clear_source_select_i,
  input  wire        duty_period_swap_i,
  input  wire        enable_set_i,
  input  wire        enable_clr_i,
  input  wire [7:0]  period_compare_value_i,
  input  wire [15:0] compare_value_a_i,
  input  wire        compare_a_wr_i,
  input  wire        external_trigger_input_i,
  input  wire        trigger_falling_i,
  input  wire        capture_input_0_i,
  input  wire        capture_input_1_i,
  output wire        counter_enable_bit_o,
  output wire [15:0] counter_o,
  output wire [15:0] compare_value_a_o,
  output wire        timer_out_o,
  output wire        irq_a_o,
  output wire        irq_p_o
);

  reg        en_ff;
  reg        en_d_ff;
  reg [15:0] cnt_ff;
  reg [15:0] cca_ff;
  reg        wave_ff;
  reg        irq_a_ff;
  reg        irq_p_ff;
  reg        trig_d_ff;
  reg        cap0_d_ff;
  reg        cap1_d_ff;

  wire [1:0] mode = {mode_select_hi_i, mode_select_lo_i};
  wire [1:0] iof  = {output_function_hi_i, output_function_lo_i};
  wire       pwm_mode = (mode == `STP_MODE_PWM) && (iof != `STP_IO_SINGLE);
  wire       sp_mode  = (mode == `STP_MODE_PWM) && (iof == `STP_IO_SINGLE);
  wire       cap_mode = (mode == `STP_MODE_CAPTURE);

  // Edge check shared by trigger and both capture pins
  function edge_hit;
    input [1:0] sel;
    input       prev;
    input       cur;
    begin
      case (sel)
        `STP_EDGE_RISE: edge_hit = ~prev & cur;
        `STP_EDGE_FALL: edge_hit = prev & ~cur;
        `STP_EDGE_BOTH: edge_hit = prev ^ cur;
        default:        edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Period length in timer clocks; zero means full 65536 range
  function [16:0] period_len;
    input [7:0] p;
    begin
      period_len = (p == 8'h00) ? 17'h10000 : {1'b0, p, 8'h00};
    end
  endfunction

  wire [16:0] cnt_next1  = {1'b0, cnt_ff} + 17'h00001;
  // Match on the last count of the period so the clear makes it exactly P*256 long, or 65536 when P is zero
  wire        p_match    = ({1'b0, cnt_ff} == (period_len(period_compare_value_i) - 17'h00001));
  wire        a_match    = (cnt_ff == cca_ff);
  wire        en_rise    = en_ff & ~en_d_ff;
  wire        trig_edge  = edge_hit(trigger_falling_i ? `STP_EDGE_FALL : `STP_EDGE_RISE,
                                    trig_d_ff, external_trigger_input_i);
  wire        cap_edge   = edge_hit(iof, cap0_d_ff, capture_input_0_i) |
                           edge_hit(iof, cap1_d_ff, capture_input_1_i);
  wire        run        = en_ff & ~en_rise & tick_i;

  // PWM clear source depends only on the swap bit
  wire        pwm_clear  = duty_period_swap_i ? a_match : p_match;

  // Duty comparison against the count one behind the tick being shown
  wire [16:0] duty_len   = duty_period_swap_i ? period_len(period_compare_value_i) :
                           {1'b0, cca_ff};
  wire [16:0] per_len    = duty_period_swap_i ? ({1'b0, cca_ff} + 17'h00001) :
                           period_len(period_compare_value_i);
  wire        duty_full  = (duty_len >= per_len);
  wire        pwm_active = duty_full | ({1'b0, cnt_ff} < duty_len);

  reg         nxt_en;
  reg  [15:0] nxt_cnt;
  reg  [15:0] nxt_cca;
  reg         nxt_irq_a;
  reg         nxt_irq_p;

  always @* begin
    nxt_en    = en_ff;
    nxt_cnt   = cnt_ff;
    nxt_cca   = compare_a_wr_i ? compare_value_a_i : cca_ff;
    nxt_irq_a = 1'b0;
    nxt_irq_p = 1'b0;
    if (enable_set_i)
      nxt_en = 1'b1;
    else if (enable_clr_i)
      nxt_en = 1'b0;
    if (sp_mode && trig_edge)
      nxt_en = 1'b1;
    if (en_rise) begin
      nxt_cnt = `STP_CNT_RST;
    end else if (run) begin
      nxt_cnt = cnt_next1[15:0];
      if (pwm_mode) begin
        if (pwm_clear)
          nxt_cnt = `STP_CNT_RST;
        nxt_irq_a = a_match;
        nxt_irq_p = p_match;
      end else if (sp_mode) begin
        if (a_match) begin
          nxt_cnt   = cnt_ff; // Counter stops on the A match
          nxt_en    = 1'b0;
          nxt_irq_a = 1'b1;
        end
      end else if (cap_mode) begin
        if (p_match) begin
          nxt_cnt   = `STP_CNT_RST;
          nxt_irq_p = 1'b1;
        end
      end
    end
    if (cap_mode && en_ff && cap_edge) begin
      nxt_cca   = cnt_ff;
      nxt_irq_a = 1'b1;
    end
  end

  // Wave level before active-level and invert shaping
  reg nxt_wave;
  always @* begin
    nxt_wave = 1'b0;
    if (pwm_mode) begin
      case (iof)
        `STP_IO_INACTIVE: nxt_wave = 1'b0;
        `STP_IO_ACTIVE:   nxt_wave = 1'b1;
        default:          nxt_wave = en_ff & pwm_active;
      endcase
    end else if (sp_mode) begin
      nxt_wave = nxt_en;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      en_ff     <= 1'b0;
      en_d_ff   <= 1'b0;
      cnt_ff    <= `STP_CNT_RST;
      cca_ff    <= 16'h0000;
      wave_ff   <= 1'b0;
      irq_a_ff  <= 1'b0;
      irq_p_ff  <= 1'b0;
      trig_d_ff <= 1'b0;
      cap0_d_ff <= 1'b0;
      cap1_d_ff <= 1'b0;
    end else if (ce_i) begin
      en_ff     <= nxt_en;
      en_d_ff   <= en_ff;
      cnt_ff    <= nxt_cnt;
      cca_ff    <= nxt_cca;
      wave_ff   <= nxt_wave;
      irq_a_ff  <= nxt_irq_a;
      irq_p_ff  <= nxt_irq_p;
      trig_d_ff <= external_trigger_input_i;
      cap0_d_ff <= capture_input_0_i;
      cap1_d_ff <= capture_input_1_i;
    end
  end

  // Capture mode has no output; level and invert bits shape the output in every other mode
  assign timer_out_o = cap_mode ? 1'b0 :
                       ((wave_ff ~^ initial_level_select_i) ^ output_invert_i);
  assign counter_enable_bit_o = en_ff;
  assign counter_o            = cnt_ff;
  assign compare_value_a_o    = cca_ff;
  assign irq_a_o              = irq_a_ff;
  assign irq_p_o              = irq_p_ff;

endmodule // stp_timer

// ===== stp_timer_checker.sv
// Port-level assertions for the standard timer core
`timescale 1ns/100ps
`include "stp_map.vh"
module stp_timer_checker (
  input wire logic        clk_i, rst_i, ce_i,
  input wire logic        mode_select_hi_i, mode_select_lo_i,
  input wire logic        output_function_hi_i, output_function_lo_i,
  input wire logic        initial_level_select_i, output_invert_i,
  input wire logic        enable_set_i, enable_clr_i,
  input wire logic        counter_enable_bit_o, timer_out_o, irq_a_o,
  input wire logic [15:0] counter_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [1:0] md  = {mode_select_hi_i, mode_select_lo_i};
  wire [1:0] of  = {output_function_hi_i, output_function_lo_i};
  wire       sp  = (md == `STP_MODE_PWM) && (of == `STP_IO_SINGLE);
  wire       frc = (md == `STP_MODE_PWM) && !output_function_hi_i;
  wire       cof = (md == `STP_MODE_CAPTURE) && (of == `STP_EDGE_OFF);
  sequence s_zero; ##1 counter_o == `STP_CNT_RST; endsequence
  sequence s_end; ##[0:1] !counter_enable_bit_o; endsequence
  AST_EN_SET: assert property (enable_set_i && ce_i |=> counter_enable_bit_o)
    else $error("enable not set");
  AST_EN_CLR: assert property (enable_clr_i && !enable_set_i && ce_i |=> !counter_enable_bit_o)
    else $error("enable not cleared");
  AST_CNT_ZERO: assert property ($rose(counter_enable_bit_o) && ce_i |-> s_zero)
    else $error("counter not zeroed");
  AST_CNT_HOLD: assert property (!counter_enable_bit_o |=> $stable(counter_o))
    else $error("count moved while off");
  AST_SP_END: assert property (sp && irq_a_o |-> s_end)
    else $error("pulse not ended");
  AST_SP_LEAD: assert property (sp && $rose(counter_enable_bit_o) |->
    timer_out_o == (initial_level_select_i ^ output_invert_i))
    else $error("no leading edge");
  AST_CAP_OFF: assert property ((cof)[*2] |-> !irq_a_o)
    else $error("capture while off");
  // Forced levels are judged only once the controls have settled
  AST_FORCE: assert property (frc && $stable({md, of, initial_level_select_i, output_invert_i})
    |-> timer_out_o == ((output_function_lo_i ~^ initial_level_select_i) ^ output_invert_i))
    else $error("forced level wrong");
endmodule // stp_timer_checker

// ===== stp_pins.sv
// Pin-side model: trigger source and capture pulse source
`timescale 1ns/100ps
module stp_pins (
  input  wire logic clk_i,
  output logic      trg_o,
  output logic      cap0_o,
  output logic      cap1_o
);
  initial {trg_o, cap0_o, cap1_o} = 3'h0;
  // Capture pins are only ever driven, never read back
  task automatic edge_on(input int pin, input logic lvl);
    @(negedge clk_i);
    case (pin)
      0: cap0_o = lvl;
      1: cap1_o = lvl;
      default: trg_o = lvl;
    endcase
  endtask
endmodule // stp_pins

// ===== stp_timer_tb_top.sv
// Self-checking testbench for the standard timer core
`timescale 1ns/100ps
`include "stp_map.vh"
module stp_timer_tb_top;
  logic clk_i = 0, rst_i = 1, mh = 0, ml = 0, oh = 0, ol = 0, lv = 1, inv = 0, clr = 0;
  logic sw = 0, es = 0, ec = 0, aw = 0, en, tout, ia, ip, trg, c0, c1;
  logic [7:0]  p = 8'h01;
  logic [15:0] a = 16'h0000, cnt, cap, h, q, s;
  int n_fail = 0, n_tests = 0, k, f, j;
  stp_pins u_pins (.clk_i, .trg_o(trg), .cap0_o(c0), .cap1_o(c1));
  stp_timer u_dut (.clk_i, .rst_i, .ce_i(1'b1), .tick_i(1'b1), .mode_select_hi_i(mh),
    .mode_select_lo_i(ml), .output_function_hi_i(oh), .output_function_lo_i(ol),
    .initial_level_select_i(lv), .output_invert_i(inv), .clear_source_select_i(clr),
    .duty_period_swap_i(sw), .enable_set_i(es), .enable_clr_i(ec),
    .period_compare_value_i(p), .compare_value_a_i(a), .compare_a_wr_i(aw),
    .external_trigger_input_i(trg), .trigger_falling_i(1'b0), .capture_input_0_i(c0),
    .capture_input_1_i(c1), .counter_enable_bit_o(en), .counter_o(cnt),
    .compare_value_a_o(cap), .timer_out_o(tout), .irq_a_o(ia), .irq_p_o(ip));
  initial forever #4 clk_i = ~clk_i;
  task cyc(input int n); repeat (n) @(negedge clk_i); endtask
  task chk(input logic [15:0] sn, ex);
    n_tests++;
    if (sn !== ex) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, sn, ex);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cfg(input logic [1:0] m, fn, input logic [15:0] av);
    {mh, ml} = m; {oh, ol} = fn; a = av; aw = 1; cyc(1); aw = 0;
  endtask
  task pulse(input bit on);
    if (on) es = 1; else ec = 1;
    cyc(1);
    es = 0; ec = 0;
  endtask
  // Bounded wait for a level; running out ends the run as a failure
  task wt(input bit want_ip);
    for (k = 0; k < 400 && (want_ip ? ip !== 1'b1 : en !== 1'b0); k++) begin q += ia; cyc(1); end
    if (k == 400) begin n_fail++; stop_test; end
    repeat (2) begin q += ia; cyc(1); end
  endtask
  task pwm(input logic s_, i_, input logic [1:0] fn, input logic [15:0] av, w, ex);
    sw = s_; inv = i_; cfg(2'h2, fn, av); pulse(1); cyc(8); h = 0;
    repeat (w) begin h += tout; cyc(1); end
    chk(h, ex);
    pulse(0);
  endtask
  initial begin
    cyc(16); rst_i = 0; cyc(1);
    cfg(2'h2, 2'h3, 16'h0005); q = 0; pulse(1); wt(0);
    chk(cnt, 16'h0005);
    chk(q, 16'h0001);
    u_pins.edge_on(2, 1); cyc(2);
    chk(en, 1'b1);
    wt(0); u_pins.edge_on(2, 0);
    chk(cnt, 16'h0005);
    $display("single pulse done");
    inv = 1; clr = 1; sw = 1; // Ignored while capturing
    for (f = 0; f < 4; f++) begin
      cfg(2'h1, f[1:0], 16'h0000); pulse(1); q = 0; cyc(1); s = cnt;
      for (j = 0; j < 4; j++) begin
        u_pins.edge_on(j / 2, j % 2 == 0);
        repeat (6) begin q += ia; cyc(1); end
        if (f == 0 && j == 0) chk(16'(cap - s) < 16'h0009, 1'b1);
      end
      chk(q, f == 2 ? 16'h0004 : f == 3 ? 16'h0000 : 16'h0002);
      pulse(0);
    end
    cfg(2'h1, 2'h3, 16'h0000); pulse(1); wt(1);
    chk(cnt < 16'h0003, 1'b1);
    pulse(0); s = cnt; cyc(5);
    chk(cnt, s);
    $display("capture done");
    pwm(0, 0, 2'h2, 16'h0040, 16'h0100, 16'h0040);
    pwm(0, 0, 2'h2, 16'h012C, 16'h0100, 16'h0100);
    pwm(0, 1, 2'h2, 16'h0040, 16'h0100, 16'h00C0);
    pwm(1, 0, 2'h2, 16'h0257, 16'h0258, 16'h0100);
    pwm(0, 0, 2'h0, 16'h0040, 16'h0100, 16'h0000);
    pwm(0, 0, 2'h1, 16'h0040, 16'h0100, 16'h0100);
    $display("pwm done");
    stop_test;
  end
endmodule // stp_timer_tb_top
bind stp_timer stp_timer_checker u_chk (.clk_i, .rst_i, .ce_i, .mode_select_hi_i,
  .mode_select_lo_i, .output_function_hi_i, .output_function_lo_i, .initial_level_select_i,
  .output_invert_i, .enable_set_i, .enable_clr_i, .counter_enable_bit_o, .timer_out_o,
  .irq_a_o, .counter_o);
